// [hw/grv_cfg.svh]
`ifndef GRV_CFG_SVH
`define GRV_CFG_SVH

// Clock and timing figures
`define GRV_MCLK_HZ     50000000
`define GRV_MCLK_NS     20
`define GRV_OSC_HZ      21000
`define GRV_OSC_HALF    (`GRV_MCLK_HZ / (2 * `GRV_OSC_HZ))
`define GRV_LAG_NS      3500
`define GRV_LAG_CYC     ((`GRV_LAG_NS + `GRV_MCLK_NS - 1) / `GRV_MCLK_NS)

// Bus address and frame layout
`define GRV_ADDR_HI     6'h3A
`define GRV_NUM_CH      14
`define GRV_BYTE_BITS   4'h8
`define GRV_IDLE_CODE   8'hFF
`define GRV_CODE_RST    8'h00
`define GRV_CTRL_RST    8'h00

`endif

// [hw/grv_pkg.sv]
`default_nettype none

package grv_pkg;

  // Serial slave states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_CTRL,
    ST_WDATA,
    ST_ACK,
    ST_RDATA,
    ST_MACK
  } grv_state_e;

  // Multifunction control byte, bit 7 down to bit 0
  typedef struct packed {
    logic [3:0] spare_control_bits;
    logic       clock_source_bit;
    logic       read_bank_bit;
    logic       write_bank_bit;
    logic       lag_select_bit;
  } grv_ctrl_s;

  // One channel update handed to the converter side
  typedef struct packed {
    logic [3:0] chan;
    logic [7:0] code_first;
    logic [7:0] code_second;
  } grv_dac_word_s;

endpackage

`default_nettype wire

// [hw/grv_ctrl.sv]
// Overview of operation
// - Upper six address bits must equal 111010
// - Address bit zero follows address select pin
// - Accept bytes only after start and address
// - Direction bit: zero writes, one reads
// - Reads return previously programmed channel codes
// - Write bank bit picks bank for writes
// - Read bank bit picks bank for reads
// - Clock source bit: drive oscillator or accept input
// - Lag bit delays refresh clock 3.5 us
// - Spare control bits are ignored
// - Reset: internal oscillator, refresh pin undriven
// - Data bytes are codes, MSB first
// - Refresh on falling, open switches on rising
// - Internal oscillator near 21 kHz, driven out
// - Channels refreshed in continuous round robin
// - Frame mode pin high selects standard mode
// - Byte after control programs channel one onward
`include "grv_cfg.svh"
`default_nettype none

module grv_ctrl #(
  parameter int NUM_CH   = `GRV_NUM_CH,
  parameter int OSC_HALF = `GRV_OSC_HALF,
  parameter int LAG_CYC  = `GRV_LAG_CYC
) (
  input  wire logic                  mclk_i,
  input  wire logic                  rst_i,
  input  wire logic                  dac_clk_i,
  input  wire logic                  scl_i,
  input  wire logic                  sda_i,
  output logic                       sda_o,
  output logic                       sda_oe_o,
  input  wire logic                  addr_select_pin_i,
  input  wire logic                  frame_mode_pin_i,
  input  wire logic                  refresh_clock_pin_i,
  output logic                       refresh_clock_pin_o,
  output logic                       refresh_clock_pin_oe_o,
  output logic                       refresh_sw_open_o,
  output var grv_pkg::grv_dac_word_s dac_word_o,
  output logic                       dac_load_o
);

  grv_pkg::grv_state_e   state_q;
  grv_pkg::grv_state_e   next_q;
  grv_pkg::grv_ctrl_s    ctrl_q;
  grv_pkg::grv_dac_word_s word_q;
  logic [2:0]            scl_q;
  logic [2:0]            sda_q;
  logic [1:0]            asel_q;
  logic [1:0]            fmode_q;
  logic [1:0]            ext_q;
  logic [3:0]            bitcnt_q;
  logic [7:0]            shift_q;
  logic [7:0]            tx_q;
  logic [3:0]            chan_q;
  logic                  sda_oe_q;
  logic                  nack_q;
  logic                  ctrl_seen_q;
  logic [7:0]            code_a_q [NUM_CH];
  logic [7:0]            code_b_q [NUM_CH];
  logic                  scl_rise;
  logic                  scl_fall;
  logic                  start_det;
  logic                  stop_det;
  logic                  byte_done;
  logic                  addr_match;
  logic                  wr_stb;
  logic                  ctrl_stb;
  logic                  load_rd;
  logic [7:0]            rd_code;
  logic [10:0]           osc_cnt_q;
  logic                  osc_q;
  logic [LAG_CYC-1:0]    lag_q;
  logic                  raw_clk;
  logic                  rf_q;
  logic                  rf_d;
  logic [3:0]            seq_chan_q;
  logic                  req_q;
  logic [1:0]            ack_sync_q;
  logic [1:0]            req_sync_q;
  logic                  ack_q;

  // Pin synchronisers; the first stage never feeds logic
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      scl_q   <= 3'h7;
      sda_q   <= 3'h7;
      asel_q  <= 2'h0;
      fmode_q <= 2'h0;
      ext_q   <= 2'h0;
    end
    else
    begin
      scl_q   <= {scl_q[1:0], scl_i};
      sda_q   <= {sda_q[1:0], sda_i};
      asel_q  <= {asel_q[0], addr_select_pin_i};
      fmode_q <= {fmode_q[0], frame_mode_pin_i};
      ext_q   <= {ext_q[0], refresh_clock_pin_i};
    end
  end

  // Bus events seen from the synchronised lines
  assign scl_rise  = scl_q[1] & ~scl_q[2];
  assign scl_fall  = ~scl_q[1] & scl_q[2];
  assign start_det = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
  assign stop_det  = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];
  assign byte_done = scl_fall && (bitcnt_q == `GRV_BYTE_BITS);
  // Register mode is not built, so a low frame mode pin keeps the slave silent
  assign addr_match = (shift_q[7:2] == `GRV_ADDR_HI)
                    && (shift_q[1] == asel_q[1])
                    && fmode_q[1];
  assign ctrl_stb = byte_done && (state_q == grv_pkg::ST_CTRL);
  assign wr_stb   = byte_done && (state_q == grv_pkg::ST_WDATA)
                  && (32'(chan_q) < NUM_CH);
  assign load_rd  = scl_fall && (((state_q == grv_pkg::ST_ACK)
                  && (next_q == grv_pkg::ST_RDATA))
                  || ((state_q == grv_pkg::ST_MACK) && !nack_q));
  assign sda_o    = 1'b0;
  assign sda_oe_o = sda_oe_q;

  // Read data mux; past the last channel the line is left high
  always_comb
  begin
    rd_code = `GRV_IDLE_CODE;
    if (32'(chan_q) < NUM_CH)
    begin
      rd_code = ctrl_q.read_bank_bit ? code_b_q[chan_q]
                                     : code_a_q[chan_q];
    end
  end

  // Serial slave sequencer; start and stop override every state
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q  <= grv_pkg::ST_IDLE;
      next_q   <= grv_pkg::ST_IDLE;
      bitcnt_q <= 4'h0;
      shift_q  <= 8'h00;
      tx_q     <= 8'h00;
      chan_q   <= 4'h0;
      sda_oe_q <= 1'b0;
      nack_q   <= 1'b0;
    end
    else if (start_det)
    begin
      state_q  <= grv_pkg::ST_ADDR;
      bitcnt_q <= 4'h0;
      sda_oe_q <= 1'b0;
    end
    else if (stop_det)
    begin
      state_q  <= grv_pkg::ST_IDLE;
      sda_oe_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        grv_pkg::ST_ADDR, grv_pkg::ST_CTRL, grv_pkg::ST_WDATA:
        begin
          if (scl_rise)
          begin
            shift_q  <= {shift_q[6:0], sda_q[1]};
            bitcnt_q <= bitcnt_q + 4'h1;
          end
          else if (byte_done)
          begin
            bitcnt_q <= 4'h0;
            if (state_q == grv_pkg::ST_ADDR)
            begin
              if (addr_match)
              begin
                sda_oe_q <= 1'b1;
                state_q  <= grv_pkg::ST_ACK;
                chan_q   <= 4'h0;
                next_q   <= shift_q[0] ? grv_pkg::ST_RDATA
                                       : grv_pkg::ST_CTRL;
              end
              else
              begin
                state_q <= grv_pkg::ST_IDLE;
              end
            end
            else if (state_q == grv_pkg::ST_CTRL)
            begin
              sda_oe_q <= 1'b1;
              state_q  <= grv_pkg::ST_ACK;
              next_q   <= grv_pkg::ST_WDATA;
            end
            else if (wr_stb)
            begin
              sda_oe_q <= 1'b1;
              state_q  <= grv_pkg::ST_ACK;
              next_q   <= grv_pkg::ST_WDATA;
              chan_q   <= chan_q + 4'h1;
            end
            else
            begin
              state_q <= grv_pkg::ST_IDLE;
            end
          end
        end
        grv_pkg::ST_ACK:
        begin
          if (scl_fall)
          begin
            state_q  <= next_q;
            sda_oe_q <= 1'b0;
          end
        end
        grv_pkg::ST_RDATA:
        begin
          if (scl_rise)
          begin
            bitcnt_q <= bitcnt_q + 4'h1;
          end
          else if (byte_done)
          begin
            bitcnt_q <= 4'h0;
            sda_oe_q <= 1'b0;
            state_q  <= grv_pkg::ST_MACK;
          end
          else if (scl_fall)
          begin
            tx_q     <= {tx_q[6:0], 1'b1};
            sda_oe_q <= ~tx_q[6];
          end
        end
        grv_pkg::ST_MACK:
        begin
          if (scl_rise)
          begin
            nack_q <= sda_q[1];
          end
          else if (scl_fall && nack_q)
          begin
            state_q <= grv_pkg::ST_IDLE;
          end
        end
        default:
        begin
          state_q <= grv_pkg::ST_IDLE;
        end
      endcase
      // Entering a read byte loads the code and drives its MSB
      if (load_rd)
      begin
        state_q  <= grv_pkg::ST_RDATA;
        bitcnt_q <= 4'h0;
        tx_q     <= rd_code;
        sda_oe_q <= ~rd_code[7];
        if (chan_q != 4'hF)
        begin
          chan_q <= chan_q + 4'h1;
        end
      end
    end
  end

  // Control byte; spare bits are stored but nothing reads them
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl_q      <= `GRV_CTRL_RST;
      ctrl_seen_q <= 1'b0;
    end
    else if (ctrl_stb)
    begin
      ctrl_q      <= shift_q;
      ctrl_seen_q <= 1'b1;
    end
  end

  // Code banks, one storage slot per channel
  generate
    for (genvar i = 0; i < NUM_CH; i++)
    begin : g_code
      always_ff @(posedge mclk_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          code_a_q[i] <= `GRV_CODE_RST;
          code_b_q[i] <= `GRV_CODE_RST;
        end
        else if (wr_stb && (32'(chan_q) == i))
        begin
          if (ctrl_q.write_bank_bit)
          begin
            code_b_q[i] <= shift_q;
          end
          else
          begin
            code_a_q[i] <= shift_q;
          end
        end
      end
    end
  endgenerate

  // Internal oscillator, free running from reset
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      osc_cnt_q <= 11'h000;
      osc_q     <= 1'b0;
    end
    else if (32'(osc_cnt_q) >= OSC_HALF - 1)
    begin
      osc_cnt_q <= 11'h000;
      osc_q     <= ~osc_q;
    end
    else
    begin
      osc_cnt_q <= osc_cnt_q + 11'h001;
    end
  end

  // Pin stays undriven until software picks internal mode explicitly,
  // so two devices strapped together never fight after power-up
  assign refresh_clock_pin_o    = osc_q;
  assign refresh_clock_pin_oe_o = ctrl_seen_q & ~ctrl_q.clock_source_bit;
  assign raw_clk = ctrl_q.clock_source_bit ? ext_q[1] : osc_q;
  // A shift line, not a counter: fast external clocks toggle inside the lag
  assign rf_d = ctrl_q.lag_select_bit ? lag_q[LAG_CYC-1] : raw_clk;
  assign refresh_sw_open_o = rf_q;

  // Refresh clock conditioning and round robin channel sequencer
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      lag_q      <= '0;
      rf_q       <= 1'b0;
      seq_chan_q <= 4'h0;
      req_q      <= 1'b0;
      word_q     <= '0;
      ack_sync_q <= 2'h0;
    end
    else
    begin
      lag_q      <= {lag_q[LAG_CYC-2:0], raw_clk};
      rf_q       <= rf_d;
      ack_sync_q <= {ack_sync_q[0], ack_q};
      // A falling edge while the last word is still in flight is skipped
      if (rf_q && !rf_d && (req_q == ack_sync_q[1]))
      begin
        word_q.chan        <= seq_chan_q;
        word_q.code_first  <= code_a_q[seq_chan_q];
        word_q.code_second <= code_b_q[seq_chan_q];
        req_q              <= ~req_q;
        seq_chan_q <= (32'(seq_chan_q) >= NUM_CH - 1) ? 4'h0
                                                      : seq_chan_q + 4'h1;
      end
    end
  end

  // Converter side: takes the held word when the request toggle arrives
  always_ff @(posedge dac_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      req_sync_q <= 2'h0;
      ack_q      <= 1'b0;
      dac_word_o <= '0;
      dac_load_o <= 1'b0;
    end
    else
    begin
      req_sync_q <= {req_sync_q[0], req_q};
      dac_load_o <= 1'b0;
      if (req_sync_q[1] != ack_q)
      begin
        dac_word_o <= word_q;
        dac_load_o <= 1'b1;
        ack_q      <= req_sync_q[1];
      end
    end
  end

endmodule

`default_nettype wire

// [verification/grv_ctrl_sva.sv]
`default_nettype none
module grv_ctrl_sva #(
  parameter int NUM_CH = 14
) (
  input wire logic                   mclk_i,
  input wire logic                   rst_i,
  input wire logic                   dac_clk_i,
  input wire logic                   scl_i,
  input wire logic                   sda_o,
  input wire logic                   sda_oe_o,
  input wire logic                   refresh_clock_pin_oe_o,
  input wire grv_pkg::grv_dac_word_s dac_word_o,
  input wire logic                   dac_load_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] last_q;
  logic       seen_q;
  // Last channel handed over, so the round robin order can be checked
  always_ff @(posedge dac_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      last_q <= 4'h0;
      seen_q <= 1'b0;
    end
    else if (dac_load_o)
    begin
      last_q <= dac_word_o.chan;
      seen_q <= 1'b1;
    end
  end
  // Loads are single pulses followed by at least four quiet converter clocks, at most one per falling refresh edge
  sequence s_quiet;
    !dac_load_o [*4];
  endsequence
  a_sda_open_drain: assert property (@(posedge mclk_i) disable iff (rst_i)
    !sda_o) else $error("sda output not low");
  a_sda_scl_low: assert property (@(posedge mclk_i) disable iff (rst_i)
    $changed(sda_oe_o) |-> !scl_i && !$past(scl_i, 2)) else $error("sda moved, scl high");
  a_pin_oe_scl: assert property (@(posedge mclk_i) disable iff (rst_i)
    $changed(refresh_clock_pin_oe_o) |-> !scl_i) else $error("pin drive moved early");
  // Judged from the second reset edge on, once the first edge has cleared the flops
  a_reset_quiet: assert property (@(posedge mclk_i)
    rst_i ##1 rst_i |-> !sda_oe_o && !refresh_clock_pin_oe_o) else $error("driving in reset");
  a_load_gap: assert property (@(posedge dac_clk_i) disable iff (rst_i)
    dac_load_o |=> s_quiet) else $error("load pulses too close");
  a_chan_range: assert property (@(posedge dac_clk_i) disable iff (rst_i)
    dac_load_o |-> dac_word_o.chan < NUM_CH) else $error("channel out of range");
  a_chan_order: assert property (@(posedge dac_clk_i) disable iff (rst_i)
    dac_load_o && seen_q |-> dac_word_o.chan ==
      ((last_q == 4'(NUM_CH - 1)) ? 4'h0 : last_q + 4'h1)) else $error("channel order");
  a_word_with_load: assert property (@(posedge dac_clk_i) disable iff (rst_i)
    $changed(dac_word_o) |-> dac_load_o) else $error("word changed without load");
endmodule
bind grv_ctrl grv_ctrl_sva #(.NUM_CH(NUM_CH)) grv_ctrl_sva_inst (
  .mclk_i, .rst_i, .dac_clk_i, .scl_i, .sda_o, .sda_oe_o,
  .refresh_clock_pin_oe_o, .dac_word_o, .dac_load_o
);
`default_nettype wire

// [verification/grv_mst.sv]
`default_nettype none
module grv_mst #(
  parameter int Q = 8
) (
  input  wire logic mclk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Both lines idle high
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Lines change just after a clock rise, then hold a third of a bit
  task automatic step(input logic c, input logic d);
    scl_o <= c;
    sda_o <= d;
    repeat (Q) @(posedge mclk_i);
  endtask
  // SDA falls while SCL is high; also serves as repeated start
  task automatic start();
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask
  task automatic stop();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask
  // Eight bits then the acknowledge slot; w of FF releases SDA so the slave can talk
  task automatic xfer(input logic [7:0] w, input logic nk, output logic [7:0] r,
                      output logic ack);
    logic [8:0] o;
    logic [8:0] s;
    o = {w, nk};
    for (int i = 8; i >= 0; i--)
    begin
      step(1'b0, o[i]);
      step(1'b1, o[i]);
      s[i] = sda_i;
      step(1'b0, o[i]);
    end
    r = s[8:1];
    ack = !s[0];
  endtask
endmodule
`default_nettype wire

// [verification/gamma_ref_i2c_control_bench.sv]
`default_nettype none
module gamma_ref_i2c_control_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LG = 4;
  localparam int OSC = 20;
  logic       mclk_i = 1'b0;
  logic       dclk   = 1'b0;
  logic       rst_i  = 1'b1;
  logic       sel    = 1'b0;
  logic       fm     = 1'b1;
  logic       ext_q  = 1'b0;
  logic [5:0] ec_q   = 6'h00;
  logic       scl, msda, sda_o, sda_oe, pin_o, pin_oe, sw, load;
  wire logic  sda_w  = msda & ~sda_oe;
  wire logic  pin_w  = pin_oe ? pin_o : ext_q;
  grv_pkg::grv_dac_word_s word;
  logic [7:0] codes [2][14] = '{default: 8'h00};
  int         n_fail = 0;
  int         checks = 0;
  // Core clock and an unrelated converter clock
  initial forever #10 mclk_i = ~mclk_i;
  initial forever #7.5 dclk = ~dclk;
  // Free-running external refresh clock, 60 core cycles a period
  always @(posedge mclk_i)
  begin
    ec_q <= (ec_q == 6'h1D) ? 6'h00 : ec_q + 6'h01;
    if (ec_q == 6'h1D)
      ext_q <= ~ext_q;
  end
  grv_ctrl #(.OSC_HALF(OSC), .LAG_CYC(LG)) grv_ctrl_inst (
    .mclk_i, .rst_i, .dac_clk_i(dclk), .scl_i(scl), .sda_i(sda_w), .sda_o,
    .sda_oe_o(sda_oe), .addr_select_pin_i(sel), .frame_mode_pin_i(fm),
    .refresh_clock_pin_i(pin_w), .refresh_clock_pin_o(pin_o),
    .refresh_clock_pin_oe_o(pin_oe), .refresh_sw_open_o(sw), .dac_word_o(word),
    .dac_load_o(load)
  );
  grv_mst grv_mst_inst (.mclk_i, .sda_i(sda_w), .scl_o(scl), .sda_o(msda));
  task automatic report_and_stop();
    if (n_fail == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  // A wait that runs out ends the run
  task automatic hang();
    n_fail++;
    report_and_stop();
  endtask
  task automatic wait_lvl(ref logic s, input logic v, output int n);
    for (n = 0; s !== v; n++)
    begin
      if (n > 5000)
        hang();
      @(posedge mclk_i);
    end
  endtask
  // Control byte then n codes for bank b; codes past fourteen must be refused
  task automatic wframe(input logic [7:0] ctl, input int n, input int b);
    logic [7:0] r;
    logic [7:0] d;
    logic       a;
    grv_mst_inst.start();
    grv_mst_inst.xfer(8'hE8, 1'b1, r, a);
    cmp("addr ack", 8'h01, {7'h00, a});
    grv_mst_inst.xfer(ctl, 1'b1, r, a);
    cmp("ctrl ack", 8'h01, {7'h00, a});
    for (int i = 0; i < n; i++)
    begin
      d = 8'(i * 37 + b * 128 + 3);
      if (i < 14)
        codes[b][i] = d;
      grv_mst_inst.xfer(d, 1'b1, r, a);
      cmp("data ack", {7'h00, i < 14}, {7'h00, a});
    end
    grv_mst_inst.stop();
  endtask
  // Fourteen codes back from the chosen bank, the last one refused by the master
  task automatic rframe(input int b);
    logic [7:0] r;
    logic       a;
    grv_mst_inst.start();
    grv_mst_inst.xfer(8'hE9, 1'b1, r, a);
    cmp("read addr ack", 8'h01, {7'h00, a});
    for (int i = 0; i < 14; i++)
    begin
      grv_mst_inst.xfer(8'hFF, i == 13, r, a);
      cmp("read code", codes[b][i], r);
    end
    grv_mst_inst.stop();
    cmp("sda released", 8'h00, {7'h00, sda_oe});
  endtask
  // Both select levels, a wrong upper pattern, then frame mode low
  task automatic t_addr();
    logic [7:0] r;
    logic       a;
    for (int k = 0; k < 12; k++)
    begin
      sel <= k[0];
      fm <= (k < 8);
      repeat (8) @(posedge mclk_i);
      grv_mst_inst.start();
      grv_mst_inst.xfer({(k / 4 == 1) ? 6'h2A : 6'h3A, k[1], 1'b0}, 1'b1, r, a);
      grv_mst_inst.stop();
      cmp("addr match", {7'h00, k < 4 && k[0] == k[1]}, {7'h00, a});
    end
    sel <= 1'b0;
    fm <= 1'b1;
  endtask
  // Fourteen loads in channel order, each with both banks' codes
  task automatic chk_dac();
    int n;
    n = 0;
    while (!(load === 1'b1 && word.chan === 4'h0))
    begin
      if (++n > 9000)
        hang();
      @(posedge dclk);
    end
    for (int i = 0; i < 14; i++)
    begin
      cmp("chan", 8'(i), {4'h0, word.chan});
      cmp("first bank code", codes[0][i], word.code_first);
      cmp("second bank code", codes[1][i], word.code_second);
      n = 0;
      do
      begin
        if (++n > 9000)
          hang();
        @(posedge dclk);
      end while (load !== 1'b1);
    end
  endtask
  // External rise to switch opening, without and with the lag
  task automatic t_lag();
    int n [2];
    int d;
    for (int k = 0; k < 2; k++)
    begin
      wframe(8'h08 | 8'(k), 0, 0);
      wait_lvl(ext_q, 1'b0, d);
      wait_lvl(ext_q, 1'b1, d);
      wait_lvl(sw, 1'b1, n[k]);
    end
    cmp("lag cycles", 8'(LG), 8'(n[1] - n[0]));
  endtask
  // Internal oscillator half period, timed on the driven pin level
  task automatic t_osc();
    int d;
    int n;
    wait_lvl(pin_o, 1'b0, d);
    wait_lvl(pin_o, 1'b1, d);
    wait_lvl(pin_o, 1'b0, n);
    cmp("osc half period", 8'(OSC), 8'(n));
  endtask
  initial
  begin
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    cmp("pin drive at reset", 8'h00, {7'h00, pin_oe});
    t_addr();
    wframe(8'hF0, 15, 0);
    cmp("pin drive internal", 8'h01, {7'h00, pin_oe});
    t_osc();
    chk_dac();
    wframe(8'h0A, 14, 1);
    cmp("pin drive external", 8'h00, {7'h00, pin_oe});
    chk_dac();
    t_lag();
    wframe(8'h0C, 0, 0);
    rframe(1);
    wframe(8'h08, 0, 0);
    rframe(0);
    report_and_stop();
  end
endmodule
`default_nettype wire
